// >>> hw/mpb_pkg.sv
package mpb_pkg;

  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned CLK_HZ   = 20_000_000;

  // ----------------------------------------------------------------------
  // Register offsets on the internal control port
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_DIRECTION  = 8'h00;
  localparam logic [7:0] REG_INPUT      = 8'h01;
  localparam logic [7:0] REG_OUTPUT     = 8'h02;
  localparam logic [7:0] REG_DEBOUNCE   = 8'h03;
  localparam logic [7:0] REG_GLOBAL     = 8'h04;
  localparam logic [7:0] REG_OUT_CLEAR  = 8'h05;
  localparam logic [7:0] REG_OUT_SET    = 8'h06;
  localparam logic [7:0] REG_PULL_A     = 8'h07;
  localparam logic [7:0] REG_PULL_B     = 8'h08;
  localparam logic [7:0] REG_OPEN_DRAIN = 8'h09;
  localparam logic [7:0] REG_PAD_SEL_A  = 8'h0A;
  localparam logic [7:0] REG_PAD_SEL_B  = 8'h0B;
  localparam logic [7:0] REG_EDGE_A     = 8'h0C;
  localparam logic [7:0] REG_EDGE_B     = 8'h0D;
  localparam logic [7:0] REG_EVT_MASK   = 8'h0E;
  localparam logic [7:0] REG_SEC_PULL_A = 8'h10;
  localparam logic [7:0] REG_SEC_PULL_B = 8'h11;
  localparam logic [7:0] REG_SEC_OD     = 8'h12;

  // ----------------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned GLOBAL_EN_BIT = 0;
  localparam int unsigned CLK_SEL_BIT   = 0;
  localparam logic [7:0]  SEC_CAPABLE   = 8'hF6;
  localparam logic [7:0]  SEC_IS_OUTPUT = 8'h76;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_GLOBAL    = 8'h01;
  localparam logic [7:0]  RST_MASK      = 8'hFF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned DEBOUNCE_TIME_US = 1000;
  localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLOW_CLK_HZ      = 32_768;
  localparam int unsigned SYNC_CLK_HZ      = 2_200_000;
  localparam logic [8:0]  SLOW_HALF_CYC    = 9'(CLK_HZ / (2 * SLOW_CLK_HZ));
  localparam logic [2:0]  SYNC_HALF_CYC    = 3'(CLK_HZ / (2 * SYNC_CLK_HZ));

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpb_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } mpb_pads_t;

  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  dout;
    logic [7:0]  dben;
    logic [7:0]  gctl;
    logic [7:0]  pad_a;
    logic [7:0]  pad_b;
    logic [7:0]  pua;
    logic [7:0]  pdb;
    logic [7:0]  od;
    logic [7:0]  edge_r;
    logic [7:0]  edge_f;
    logic [7:0]  mask;
    logic [7:0]  spu;
    logic [7:0]  spd;
    logic [7:0]  sod;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  samp;
    logic [7:0]  filt;
    logic [7:0]  prev;
    logic [14:0] dbcnt;
    logic [8:0]  slow_cnt;
    logic        slow_clk;
    logic [2:0]  sync_cnt;
    logic        sync_clk;
    logic [7:0]  rdata;
    logic [7:0]  evt;
    logic        wake;
  } mpb_state_t;

endpackage : mpb_pkg

// >>> hw/mpb_bank.sv
`timescale 1ns/100ps
module mpb_bank #(
  parameter int unsigned DEBOUNCE_CYCLES = mpb_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire mpb_pkg::mpb_req_t reg_req,
  output logic [7:0]             reg_rdata,
  input  wire logic [7:0]        pad_in,
  output mpb_pkg::mpb_pads_t     pads,
  input  wire logic              io_supply_domain,
  input  wire logic              otp_sysen_en,
  input  wire logic              bus_power_detect_out,
  input  wire logic              seq_regulator_enable_second,
  input  wire logic              seq_system_enable_first,
  input  wire logic              seq_system_enable_second,
  input  wire logic              slow_clock_gate_en,
  output logic                   power_hold_input,
  output logic [7:0]             pin_event,
  output logic                   wake_event
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 32768) begin : g_bad_debounce
    $error("DEBOUNCE_CYCLES must lie between 1 and 32768.");
  end

  localparam logic [14:0] DB_LAST = 15'(DEBOUNCE_CYCLES - 1);

  mpb_pkg::mpb_state_t s_q;
  mpb_pkg::mpb_state_t s_d;
  logic [7:0]          sec;
  logic [7:0]          sec_val;

  assign sec = s_q.pad_a & mpb_pkg::SEC_CAPABLE;

  // ----------------------------------------------------------------------
  // Secondary function values
  // ----------------------------------------------------------------------
  always_comb begin
    sec_val    = 8'h00;
    sec_val[1] = bus_power_detect_out;
    sec_val[2] = seq_regulator_enable_second;
    sec_val[4] = seq_system_enable_first & otp_sysen_en;
    sec_val[5] = s_q.pad_b[mpb_pkg::CLK_SEL_BIT] ? s_q.sync_clk
                 : (s_q.slow_clk & slow_clock_gate_en);
    sec_val[6] = seq_system_enable_second & otp_sysen_en;
  end

  // ----------------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------------
  // Open drain only ever pulls low, so the enable drops whenever a one is wanted.
  always_comb begin
    pads = '0;
    for (int i = 0; i < mpb_pkg::NUM_PINS; i++) begin
      if (sec[i]) begin
        pads.oe[i]        = mpb_pkg::SEC_IS_OUTPUT[i] & (~s_q.sod[i] | ~sec_val[i]);
        pads.out[i]       = sec_val[i] & ~s_q.sod[i];
        pads.pull_up[i]   = s_q.spu[i];
        pads.pull_down[i] = s_q.spd[i];
      end else begin
        pads.oe[i]        = s_q.dir[i] & (~s_q.od[i] | ~s_q.dout[i]);
        pads.out[i]       = s_q.dout[i] & ~s_q.od[i];
        pads.pull_up[i]   = s_q.pua[i];
        pads.pull_down[i] = s_q.pdb[i];
      end
    end
    if (!s_q.gctl[mpb_pkg::GLOBAL_EN_BIT]) begin
      pads.oe = 8'h00;
    end
    if (!io_supply_domain) begin
      pads.oe[4] = 1'b0;
      pads.oe[6] = 1'b0;
    end
  end

  assign power_hold_input = sec[7] & s_q.filt[7];
  assign pin_event        = s_q.evt;
  assign wake_event       = s_q.wake;
  assign reg_rdata        = s_q.rdata;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       tick;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] ev;
    tick  = 1'b0;
    rise  = 8'h00;
    fall  = 8'h00;
    ev    = 8'h00;
    s_d   = s_q;

    s_d.sync1 = pad_in;
    s_d.sync2 = s_q.sync1;

    // A shared tick keeps the filter to two bits per pin instead of a counter each.
    tick = (s_q.dbcnt == DB_LAST);
    s_d.dbcnt = tick ? 15'h0000 : s_q.dbcnt + 15'h0001;
    if (tick) begin
      s_d.samp = s_q.sync2;
    end
    for (int i = 0; i < mpb_pkg::NUM_PINS; i++) begin
      if (!s_q.dben[i]) begin
        s_d.filt[i] = s_q.sync2[i];
      end else if (tick && s_q.samp[i] == s_q.sync2[i]) begin
        s_d.filt[i] = s_q.sync2[i];
      end
    end

    s_d.prev = s_q.filt;
    rise     = s_q.filt & ~s_q.prev;
    fall     = ~s_q.filt & s_q.prev;
    ev       = ((rise & s_q.edge_r) | (fall & s_q.edge_f))
               & {8{s_q.gctl[mpb_pkg::GLOBAL_EN_BIT]}};
    // Masked pins must not wake the device either, or masking could not silence a source.
    s_d.evt  = ev & ~s_q.mask;
    s_d.wake = |s_d.evt;

    if (s_q.slow_cnt == mpb_pkg::SLOW_HALF_CYC - 9'h001) begin
      s_d.slow_cnt = 9'h000;
      s_d.slow_clk = ~s_q.slow_clk;
    end else begin
      s_d.slow_cnt = s_q.slow_cnt + 9'h001;
    end
    if (s_q.sync_cnt == mpb_pkg::SYNC_HALF_CYC - 3'h1) begin
      s_d.sync_cnt = 3'h0;
      s_d.sync_clk = ~s_q.sync_clk;
    end else begin
      s_d.sync_cnt = s_q.sync_cnt + 3'h1;
    end

    if (reg_req.wr) begin
      unique case (reg_req.addr)
        mpb_pkg::REG_DIRECTION:  s_d.dir    = reg_req.wdata;
        mpb_pkg::REG_OUTPUT:     s_d.dout   = reg_req.wdata;
        mpb_pkg::REG_DEBOUNCE:   s_d.dben   = reg_req.wdata;
        mpb_pkg::REG_GLOBAL:     s_d.gctl   = reg_req.wdata & mpb_pkg::RST_GLOBAL;
        mpb_pkg::REG_OUT_CLEAR:  s_d.dout   = s_q.dout & ~reg_req.wdata;
        mpb_pkg::REG_OUT_SET:    s_d.dout   = s_q.dout | reg_req.wdata;
        mpb_pkg::REG_PULL_A:     s_d.pua    = reg_req.wdata;
        mpb_pkg::REG_PULL_B:     s_d.pdb    = reg_req.wdata;
        mpb_pkg::REG_OPEN_DRAIN: s_d.od     = reg_req.wdata;
        mpb_pkg::REG_PAD_SEL_A:  s_d.pad_a  = reg_req.wdata;
        mpb_pkg::REG_PAD_SEL_B:  s_d.pad_b  = reg_req.wdata;
        mpb_pkg::REG_EDGE_A:     s_d.edge_r = reg_req.wdata;
        mpb_pkg::REG_EDGE_B:     s_d.edge_f = reg_req.wdata;
        mpb_pkg::REG_EVT_MASK:   s_d.mask   = reg_req.wdata;
        mpb_pkg::REG_SEC_PULL_A: s_d.spu    = reg_req.wdata;
        mpb_pkg::REG_SEC_PULL_B: s_d.spd    = reg_req.wdata;
        mpb_pkg::REG_SEC_OD:     s_d.sod    = reg_req.wdata;
        default: ;
      endcase
    end

    if (reg_req.rd) begin
      unique case (reg_req.addr)
        mpb_pkg::REG_DIRECTION:  s_d.rdata = s_q.dir;
        mpb_pkg::REG_INPUT:      s_d.rdata = s_q.filt & ~s_q.dir & ~sec;
        mpb_pkg::REG_OUTPUT:     s_d.rdata = s_q.dout;
        mpb_pkg::REG_DEBOUNCE:   s_d.rdata = s_q.dben;
        mpb_pkg::REG_GLOBAL:     s_d.rdata = s_q.gctl;
        mpb_pkg::REG_PULL_A:     s_d.rdata = s_q.pua;
        mpb_pkg::REG_PULL_B:     s_d.rdata = s_q.pdb;
        mpb_pkg::REG_OPEN_DRAIN: s_d.rdata = s_q.od;
        mpb_pkg::REG_PAD_SEL_A:  s_d.rdata = s_q.pad_a;
        mpb_pkg::REG_PAD_SEL_B:  s_d.rdata = s_q.pad_b;
        mpb_pkg::REG_EDGE_A:     s_d.rdata = s_q.edge_r;
        mpb_pkg::REG_EDGE_B:     s_d.rdata = s_q.edge_f;
        mpb_pkg::REG_EVT_MASK:   s_d.rdata = s_q.mask;
        mpb_pkg::REG_SEC_PULL_A: s_d.rdata = s_q.spu;
        mpb_pkg::REG_SEC_PULL_B: s_d.rdata = s_q.spd;
        mpb_pkg::REG_SEC_OD:     s_d.rdata = s_q.sod;
        default:                 s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q      <= '0;
      s_q.gctl <= mpb_pkg::RST_GLOBAL;
      s_q.mask <= mpb_pkg::RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence set_write;
    reg_req.wr && reg_req.addr == mpb_pkg::REG_OUT_SET;
  endsequence

  sequence clear_write;
    reg_req.wr && reg_req.addr == mpb_pkg::REG_OUT_CLEAR;
  endsequence

  sequence input_read;
    reg_req.rd && reg_req.addr == mpb_pkg::REG_INPUT;
  endsequence

  a_set_out_bits: assert property (set_write |=>
    s_q.dout == ($past(s_q.dout) | $past(reg_req.wdata)))
    else $error("Set write did not merge ones into the output value.");

  a_clear_out_bits: assert property (clear_write |=>
    s_q.dout == ($past(s_q.dout) & ~$past(reg_req.wdata)))
    else $error("Clear write did not remove ones from the output value.");

  a_masked_no_event: assert property ((pin_event & $past(s_q.mask)) == 8'h00)
    else $error("Event reported on a masked pin.");

  a_two_stage_sync: assert property ((!$past(sys_rst) && !$past(sys_rst, 2)) |->
    s_q.sync2 == $past(pad_in, 2))
    else $error("Synchroniser output is not the pin level two cycles back.");

  a_supply_gates_pins: assert property (!io_supply_domain |->
    !pads.oe[4] && !pads.oe[6])
    else $error("Pin 4 or 6 driven without the I/O supply.");

  a_global_disable: assert property (!s_q.gctl[mpb_pkg::GLOBAL_EN_BIT] |->
    pads.oe == 8'h00 ##1 pin_event == 8'h00)
    else $error("Pins active while globally disabled.");

  a_rise_event: assert property ((s_q.filt[0] && !s_q.prev[0] && s_q.edge_r[0]
    && !s_q.mask[0] && s_q.gctl[mpb_pkg::GLOBAL_EN_BIT]) |=> pin_event[0] && wake_event)
    else $error("Rising edge on pin 0 gave no event.");

  a_sec_pull_source: assert property (sec[2] |->
    pads.pull_up[2] == s_q.spu[2] && pads.pull_down[2] == s_q.spd[2])
    else $error("Secondary pin 2 took primary pull settings.");

  a_regulator_enable_second_follow: assert property ((sec[2] && !s_q.sod[2]) |->
    pads.out[2] == seq_regulator_enable_second)
    else $error("Pin 2 does not follow the regulator enable sequencer.");

  a_bus_detect_drive: assert property ((sec[1] && !s_q.sod[1]
    && s_q.gctl[mpb_pkg::GLOBAL_EN_BIT]) |-> pads.oe[1] && pads.out[1] == bus_power_detect_out)
    else $error("Pin 1 does not drive the bus power detect level.");

  a_pin7_input_only: assert property (sec[7] |-> !pads.oe[7])
    else $error("Power hold pin is being driven.");

  a_debounce_hold: assert property ((s_q.dbcnt != DB_LAST) |=>
    ((s_q.filt ^ $past(s_q.filt)) & $past(s_q.dben)) == 8'h00)
    else $error("Debounced pin changed between filter ticks.");

  a_masked_no_wake: assert property ((s_q.mask == 8'hFF) |=> !wake_event)
    else $error("Wake pulse raised while every pin is masked.");

  a_input_level_read: assert property (input_read |=>
    reg_rdata == ($past(s_q.filt) & ~$past(s_q.dir) & ~$past(sec)))
    else $error("Input register did not return the input pin levels.");

  // Software may poll the read data late, so it must not drift between reads.
  a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");

endmodule : mpb_bank

// >>> bench/mpb_board.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Board side of the pins
// ----------------------------------------------------------------------
module mpb_board (
  input  wire logic               clk,
  input  wire mpb_pkg::mpb_pads_t pads,
  input  wire logic [7:0]         drv_en,
  input  wire logic [7:0]         drv_val,
  output logic [7:0]              pad_level
);
  logic [7:0] flt_q;

  // A pin that nobody drives or pulls toggles every cycle, so a stale level never passes.
  initial flt_q = 8'h55;
  always @(posedge clk) begin
    flt_q <= ~flt_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pads.oe[i]) pad_level[i] = pads.out[i];
      else if (drv_en[i]) pad_level[i] = drv_val[i];
      else if (pads.pull_up[i]) pad_level[i] = 1'b1;
      else if (pads.pull_down[i]) pad_level[i] = 1'b0;
      else pad_level[i] = flt_q[i];
    end
  end
endmodule : mpb_board

// >>> bench/mpb_bank_test.sv
`timescale 1ns/100ps
module mpb_bank_test;
  logic               clk, sys_rst, io_sup, otp, bpd, rg2, se1, se2, sgate, ph, wake;
  mpb_pkg::mpb_req_t  req;
  mpb_pkg::mpb_pads_t pads;
  logic [7:0]         rdata, pad_in, evt, drv_en, drv_val, d, v, eo;
  logic [31:0]        seed;
  int                 error_cnt, checks, cnt;
  logic [7:0]         op_addr [4] = '{8'h02, 8'h06, 8'h05, 8'h0F};

  mpb_bank #(.DEBOUNCE_CYCLES(4)) dut (
    .clk(clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .pad_in(pad_in),
    .pads(pads), .io_supply_domain(io_sup), .otp_sysen_en(otp), .bus_power_detect_out(bpd),
    .seq_regulator_enable_second(rg2), .seq_system_enable_first(se1),
    .seq_system_enable_second(se2), .slow_clock_gate_en(sgate),
    .power_hold_input(ph), .pin_event(evt), .wake_event(wake));
  mpb_board board (.clk(clk), .pads(pads), .drv_en(drv_en), .drv_val(drv_val),
    .pad_level(pad_in));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] exp_out(input logic [1:0] op, input logic [7:0] q, v);
    case (op)
      2'd0: return v;
      2'd1: return q | v;
      2'd2: return q & ~v;
      default: return q;
    endcase
  endfunction : exp_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
    step(1);
    req = '0;
    step(1);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    req = '0;
    chk(rdata, exp, msg);
    step(1);
  endtask : rdchk

  // The window outlasts the debounce filter, so a late pulse is still seen.
  task automatic hit(input int i, input logic lv, output logic [7:0] ev, output int wk);
    ev = 8'h00;
    wk = 0;
    drv_val[i] = lv;
    repeat (30) begin
      step(1);
      ev |= evt;
      wk += int'(wake === 1'b1);
    end
  endtask : hit

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    req = '0;
    {io_sup, otp, bpd, rg2, se1, se2, sgate} = 7'b1100001;
    drv_en = 8'h00;
    drv_val = 8'h00;
    seed = 32'h33ad_1f03;
    step(16);
    sys_rst = 1'b0;
    step(1);
    for (int a = 0; a <= 18; a++) begin
      if (a != 1) rdchk(8'(a), a == 4 ? 8'h01 : (a == 14 ? 8'hFF : 8'h00), "reset");
    end
    chk(pads.oe, 8'h00, "reset oe");
    $display("reset test done");
    wr(mpb_pkg::REG_DIRECTION, 8'hFF);
    eo = 8'h00;
    repeat (12) begin
      d = rnd();
      v = rnd();
      wr(op_addr[d[1:0]], v);
      eo = exp_out(d[1:0], eo, v);
      rdchk(mpb_pkg::REG_OUTPUT, eo, "out reg");
      chk(pads.out, eo, "out pins");
      chk(pads.oe, 8'hFF, "out enable");
    end
    drv_en = 8'hFF;
    repeat (4) begin
      d = rnd();
      v = rnd();
      wr(mpb_pkg::REG_DIRECTION, d);
      drv_val = v;
      step(4);
      rdchk(mpb_pkg::REG_INPUT, v & ~d, "in level");
    end
    wr(mpb_pkg::REG_DIRECTION, 8'hFF);
    wr(mpb_pkg::REG_GLOBAL, 8'h00);
    chk(pads.oe, 8'h00, "global off");
    wr(mpb_pkg::REG_GLOBAL, 8'h01);
    wr(mpb_pkg::REG_OPEN_DRAIN, 8'hFF);
    wr(mpb_pkg::REG_OUTPUT, 8'h0F);
    chk(pads.oe, 8'hF0, "od enable");
    chk(pads.out, 8'h00, "od level");
    wr(mpb_pkg::REG_OPEN_DRAIN, 8'h00);
    d = rnd();
    v = rnd();
    wr(mpb_pkg::REG_PULL_A, d);
    wr(mpb_pkg::REG_PULL_B, v);
    chk(pads.pull_up, d, "pull up");
    chk(pads.pull_down, v, "pull down");
    $display("primary test done");
    wr(mpb_pkg::REG_PAD_SEL_A, 8'hF6);
    wr(mpb_pkg::REG_SEC_PULL_A, 8'hFF);
    chk(pads.pull_up, (d & 8'h09) | 8'hF6, "sec pull");
    repeat (8) begin
      v = rnd();
      {bpd, rg2, se1, se2, otp, io_sup} = v[5:0];
      wr(mpb_pkg::REG_OUTPUT, rnd());
      d = {4'h0, pads.out[6], pads.out[4], pads.out[2], pads.out[1]};
      chk(d, 8'({se2 & otp, se1 & otp, rg2, bpd}), "sec out");
      if (otp) chk(8'(pads.oe[6]), 8'(io_sup), "supply gate");
      chk(8'(pads.oe[4]), 8'(io_sup), "supply gate 4");
    end
    wr(mpb_pkg::REG_SEC_OD, 8'h02);
    wr(mpb_pkg::REG_SEC_PULL_B, 8'hF6);
    chk(8'({pads.oe[1], pads.out[1]}), 8'({~bpd, 1'b0}), "sec od");
    chk(pads.pull_down & 8'hF6, 8'hF6, "sec pull down");
    for (int b = 0; b < 2; b++) begin
      drv_val[7] = b[0];
      step(5);
      chk(8'(ph), 8'(b), "power hold");
    end
    // Pass 2 watches the fallback clock, pass 1 the gated slow clock, pass 0 the gate shut.
    for (int s = 2; s >= 0; s--) begin
      sgate = (s != 0);
      wr(mpb_pkg::REG_PAD_SEL_B, 8'(s == 2));
      step(10);
      cnt = 0;
      repeat (s == 2 ? 20 * mpb_pkg::SYNC_HALF_CYC : 2 * mpb_pkg::SLOW_HALF_CYC) begin
        v[0] = pads.out[5];
        step(1);
        cnt += int'(pads.out[5] !== v[0]);
      end
      chk(8'(cnt), s == 2 ? 8'h14 : (s == 1 ? 8'h02 : 8'h00), "clk");
    end
    wr(mpb_pkg::REG_PAD_SEL_A, 8'h00);
    $display("secondary test done");
    drv_val = 8'h00;
    wr(mpb_pkg::REG_DIRECTION, 8'h00);
    wr(mpb_pkg::REG_EDGE_A, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(mpb_pkg::REG_EVT_MASK, i[0] ? 8'hFF : ~(8'h01 << i));
      hit(i, 1'b1, d, cnt);
      chk(d, i[0] ? 8'h00 : 8'h01 << i, "rise evt");
      chk(8'(cnt), i[0] ? 8'h00 : 8'h01, "rise wake");
      hit(i, 1'b0, d, cnt);
      chk(d | 8'(cnt), 8'h00, "fall off");
    end
    wr(mpb_pkg::REG_EDGE_A, 8'h00);
    wr(mpb_pkg::REG_EDGE_B, 8'h08);
    wr(mpb_pkg::REG_EVT_MASK, 8'hF7);
    hit(3, 1'b1, d, cnt);
    chk(d | 8'(cnt), 8'h00, "rise off");
    hit(3, 1'b0, d, cnt);
    chk(d, 8'h08, "fall evt");
    chk(8'(cnt), 8'h01, "fall wake");
    wr(mpb_pkg::REG_DEBOUNCE, 8'h08);
    wr(mpb_pkg::REG_EDGE_A, 8'h08);
    drv_val[3] = 1'b1;
    step(1);
    hit(3, 1'b0, d, cnt);
    chk(d | 8'(cnt), 8'h00, "glitch");
    hit(3, 1'b1, d, cnt);
    chk(d, 8'h08, "debounced");
    $display("event test done");
    finish_test();
  end
endmodule : mpb_bank_test
